// ===== dv/usart_sync_master_receiver_tb.sv
/*
 Bench of the serial receive port: AHB-Lite master tasks and register-level tests.
 Assumes usr_rx with its default two-deep buffer and the slave model on the data pin.
*/
`timescale 1ns/1ns
`default_nettype none
module usart_sync_master_receiver_tb;
	// Characters in the order the slave sends them, first in the low bits.
	localparam logic [71:0] CHARS = {9'h07E, 9'h012, 9'h181, 9'h0FF, 9'h05A, 9'h0C3, 9'h1A5, 9'h035};
	logic             hclk, hresetn, hsel, hwrite, sync, pol, nine;
	logic [1:0]       htrans;
	logic [2:0]       hsize;
	logic [31:0]      haddr, hwdata;
	wire logic        hreadyout, hresp, rx_dt_i, ck_o, ck_oe, rx_irq, wake_irq;
	wire logic [31:0] hrdata;
	int               miscompares, samples_checked, cycles, i;
	usr_rx dut_u (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_dt_i(rx_dt_i),
		.ck_o(ck_o), .ck_oe(ck_oe), .rx_irq(rx_irq), .wake_irq(wake_irq));
	usr_slave_model #(.CHARS(CHARS)) slave_u (
		.hclk(hclk), .ck_i(ck_o), .ck_oe_i(ck_oe), .sync_i(sync), .pol_i(pol),
		.nine_i(nine), .dt_o(rx_dt_i));
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// A hang is cut short well after the few thousand cycles the tests need.
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			end_sim();
		end
	end
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// One single transfer; entered just after a rising edge, the answer waited for.
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(a, 1'b1, d, r);
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(a, 1'b0, 32'h0, r);
		cmp(r, e);
	endtask
	// Polls a field until it shows the value; a bound keeps a dead receiver from hanging.
	task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
		logic [31:0] r;
		int n;
		n = 0;
		bus(a, 1'b0, 32'h0, r);
		while ((r & m) !== v && n < 400) begin
			bus(a, 1'b0, 32'h0, r);
			n++;
		end
		cmp(r & m, v);
	endtask
	initial begin
		{hresetn, hsel, hwrite, sync, pol, nine, htrans, haddr, hwdata} = 72'h0;
		hsize = 3'h2;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk(8'h0C, 32'h40);
		chk(8'h04, 32'h0);
		cmp({30'h0, ck_oe, ck_o}, 32'h1);
		wr(8'h1C, 32'hFF);
		chk(8'h1C, 32'h0);
		$display("reset and map test done");
		wr(8'h10, 32'h3);
		wr(8'h14, 32'h12);
		wr(8'h08, 32'h3);
		wr(8'h18, 32'h2);
		sync <= 1'b1;
		wr(8'h04, 32'h80);
		wr(8'h04, 32'hA0);
		cmp({31'h0, ck_oe}, 32'h1);
		// The engine leaves idle one cycle after single receive lands.
		@(posedge hclk);
		chk(8'h0C, 32'h0);
		poll(8'h18, 32'h1, 32'h1);
		@(negedge hclk);
		cmp({31'h0, rx_irq}, 32'h1);
		@(posedge hclk);
		chk(8'h00, 32'h35);
		chk(8'h04, 32'h80);
		$display("single receive test done");
		pol <= 1'b1;
		wr(8'h0C, 32'h10);
		nine <= 1'b1;
		wr(8'h04, 32'hE0);
		poll(8'h18, 32'h1, 32'h1);
		chk(8'h04, 32'hC1);
		chk(8'h00, 32'hA5);
		chk(8'h04, 32'hC0);
		$display("nine bit test done");
		wr(8'h04, 32'hD0);
		poll(8'h04, 32'h2, 32'h2);
		chk(8'h00, 32'hC3);
		chk(8'h04, 32'hD2);
		chk(8'h00, 32'h5A);
		chk(8'h18, 32'h2);
		wr(8'h04, 32'hC0);
		// The overrun flag drops one cycle after the continuous enable is seen low.
		@(posedge hclk);
		chk(8'h04, 32'hC0);
		$display("continuous overrun test done");
		for (i = 0; i < 3; i++) begin
			wr(8'h04, 32'hE0);
			poll(8'h04, 32'h20, 32'h0);
		end
		chk(8'h04, 32'hC3);
		chk(8'h00, 32'h81);
		chk(8'h04, 32'hC0);
		chk(8'h00, 32'h12);
		$display("single overrun test done");
		// Dropping the port enable clears a continuous overrun and empties the buffer.
		wr(8'h04, 32'hD0);
		poll(8'h04, 32'h2, 32'h2);
		wr(8'h04, 32'h50);
		@(posedge hclk);
		chk(8'h04, 32'h50);
		chk(8'h18, 32'h2);
		cmp({31'h0, ck_oe}, 32'h0);
		wr(8'h04, 32'h80);
		$display("port disable test done");
		wr(8'h08, 32'h0);
		sync <= 1'b0;
		wr(8'h0C, 32'h02);
		i = 0;
		while (wake_irq !== 1'b1 && i < 100) begin
			@(negedge hclk);
			i++;
		end
		cmp({31'h0, wake_irq}, 32'h1);
		@(posedge hclk);
		poll(8'h0C, 32'h42, 32'h40);
		$display("wake test done");
		end_sim();
	end
endmodule
`default_nettype wire

// ===== dv/usr_rx_asserts.sv
/*
 Checker of the serial receive port, bound to usr_rx, seeing its ports only.
 Assumes polarity is changed only while no character is being clocked in.
*/
`timescale 1ns/1ns
`default_nettype none
module usr_rx_chk (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        ck_o,
	input wire logic        ck_oe,
	input wire logic        rx_irq,
	input wire logic        wake_irq
);
	logic       ap_q, apw_q, ovr_q, pol_q, sm_q, en_q, ie_q, wk_q, ckp_q;
	logic [7:0] apa_q, div_q, hc_q;
	logic       take;
	logic       wd;
	// Address phase taken and write data phase, as the slave sees them.
	assign take = hsel & hready & htrans[1];
	assign wd   = ap_q & apw_q;
	// Mirror of the settings that the properties need; overrun is known once software saw it.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{ap_q, apw_q, ovr_q, pol_q, sm_q, en_q, ie_q, wk_q, ckp_q} <= 9'h000;
			{apa_q, div_q, hc_q} <= 24'h000000;
		end else begin
			ap_q  <= take;
			apw_q <= hwrite;
			apa_q <= haddr[7:0];
			ckp_q <= ck_o;
			hc_q  <= (ck_o != ckp_q) ? 8'h01 : hc_q + {7'h00, hc_q != 8'hFF};
			if (wd && apa_q == 8'h04) en_q <= hwdata[7];
			if (wd && apa_q == 8'h08) sm_q <= hwdata[0] & hwdata[1];
			if (wd && apa_q == 8'h0C) {pol_q, wk_q} <= {hwdata[4], hwdata[1]};
			if (wd && apa_q == 8'h10) div_q <= hwdata[7:0];
			if (wd && apa_q == 8'h18) ie_q <= hwdata[1];
			if (ap_q && !apw_q && apa_q == 8'h04 && hrdata[1]) ovr_q <= 1'b1;
			else if ((wd && apa_q == 8'h04) || (take && !hwrite && haddr[7:0] == 8'h00))
				ovr_q <= 1'b0;
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_bus_okay;
		hreadyout && !hresp;
	endproperty
	a_bus_okay: assert property (p_bus_okay) else $error("slave not ready or not okay");
	property p_bc_fmt;
		take && !hwrite && haddr[7:0] == 8'h0C |=> hrdata[31:8] == 24'h0 && hrdata[7] == 1'b0
			&& hrdata[5] == 1'b0 && hrdata[2] == 1'b0;
	endproperty
	a_bc_fmt: assert property (p_bc_fmt) else $error("baud control reserved bits set");
	property p_pol_idle;
		wd && apa_q == 8'h0C && sm_q && en_q |-> ##[1:3] ck_o == pol_q;
	endproperty
	a_pol_idle: assert property (p_pol_idle) else $error("clock idle level wrong");
	property p_sgl_start;
		wd && apa_q == 8'h04 && hwdata[7] && hwdata[5] && !hwdata[4] && sm_q && !ovr_q
			|-> ##[2:40] ck_o != pol_q;
	endproperty
	a_sgl_start: assert property (p_sgl_start) else $error("no clock after start");
	property p_ovr_quiet;
		ovr_q |-> $stable(ck_o);
	endproperty
	a_ovr_quiet: assert property (p_ovr_quiet) else $error("clock runs in overrun");
	property p_half_len;
		$changed(ck_o) && ck_o == pol_q && ck_oe && $past(ck_oe) && sm_q && pol_q == $past(pol_q, 4)
			|-> {1'b0, hc_q} == {div_q, 1'b0} + 9'd2;
	endproperty
	a_half_len: assert property (p_half_len) else $error("clock half period wrong");
	property p_irq_en;
		rx_irq |-> $past(ie_q);
	endproperty
	a_irq_en: assert property (p_irq_en) else $error("receive request while disabled");
	property p_wake_en;
		wake_irq |-> $past(wk_q) && !$past(sm_q);
	endproperty
	a_wake_en: assert property (p_wake_en) else $error("wake request while disabled");
	property p_wake_pulse;
		wake_irq |=> !wake_irq;
	endproperty
	a_wake_pulse: assert property (p_wake_pulse) else $error("wake request too long");
endmodule
bind usr_rx usr_rx_chk chk_u (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .ck_o(ck_o), .ck_oe(ck_oe), .rx_irq(rx_irq),
	.wake_irq(wake_irq));
`default_nettype wire

// ===== dv/usr_slave_model.sv
/*
 Synchronous serial slave: answers the master clock with characters from a list, LSB first.
 Assumes the bench tells it the mode, the clock polarity and the character length.
*/
`timescale 1ns/1ns
`default_nettype none
module usr_slave_model #(
	parameter logic [71:0] CHARS = 72'h0
) (
	input  wire logic hclk,
	input  wire logic ck_i,
	input  wire logic ck_oe_i,
	input  wire logic sync_i,
	input  wire logic pol_i,
	input  wire logic nine_i,
	output var  logic dt_o
);
	logic       ck_q, act_q;
	logic [3:0] bit_q;
	logic [2:0] chr_q, tog_q;
	logic [8:0] cur;
	assign cur = CHARS[9*chr_q +: 9];
	initial begin
		{ck_q, act_q, dt_o, bit_q, chr_q, tog_q} = 13'h1000;
	end
	// Bits change on the leading clock edge and hold through the trailing one; a released
	// line toggles so that a stale level can never pass for data.
	always @(posedge hclk) begin
		ck_q  <= ck_i;
		tog_q <= tog_q + 3'h1;
		if (!(sync_i && ck_oe_i)) begin
			if (tog_q == 3'h7)
				dt_o <= ~dt_o;
		end else if (ck_i != ck_q && ck_i != pol_i) begin
			dt_o  <= cur[bit_q];
			act_q <= 1'b1;
		end else if (ck_i != ck_q && act_q) begin
			act_q <= 1'b0;
			bit_q <= bit_q + 4'h1;
			if (bit_q == (nine_i ? 4'h8 : 4'h7)) begin
				bit_q <= 4'h0;
				chr_q <= chr_q + 3'h1;
				dt_o  <= ~dt_o;
			end
		end
	end
endmodule
`default_nettype wire

// ===== rtl/usr_brg.v
/*
 Baud timer of the serial receive port: a free-running 8- or 16-bit divider.
 Assumes the divisor is stable between restarts and one clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module usr_brg #(
	parameter WIDTH = 16
) (
	input  wire             hclk,
	input  wire             hresetn,
	input  wire [WIDTH-1:0] div_i,
	input  wire             wide_i,
	input  wire             restart_i,
	output reg              tick_o
);
	reg  [WIDTH-1:0] cnt_q;
	wire [WIDTH-1:0] lim;

	// In narrow mode the upper half of the divisor is ignored.
	assign lim = wide_i ? div_i : {{(WIDTH-8){1'b0}}, div_i[7:0]};

	// One tick every lim+1 clocks; a restart clears the count so a new rate acts at once.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q  <= {WIDTH{1'b0}};
			tick_o <= 1'b0;
		end else if (restart_i) begin
			cnt_q  <= {WIDTH{1'b0}};
			tick_o <= 1'b0;
		end else if (cnt_q >= lim) begin
			cnt_q  <= {WIDTH{1'b0}};
			tick_o <= 1'b1;
		end else begin
			cnt_q  <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
			tick_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== rtl/usr_defs.vh
/*
 Constants of the serial receive port: register byte offsets, field positions,
 reset values and timing counts. Assumes inclusion by the receive top module; the timer and FIFO do not include it.
*/
`ifndef USR_DEFS_VH
`define USR_DEFS_VH

`define USR_OFS_DATA   8'h00
`define USR_OFS_STA    8'h04
`define USR_OFS_MODE   8'h08
`define USR_OFS_BCTL   8'h0C
`define USR_OFS_DIVLO  8'h10
`define USR_OFS_DIVHI  8'h14
`define USR_OFS_IRQ    8'h18

`define USR_STA_PORT_EN 7
`define USR_STA_NINE    6
`define USR_STA_SINGLE  5
`define USR_STA_CONT    4
`define USR_STA_OVR     1
`define USR_STA_BIT9    0

`define USR_MODE_SYNC   0
`define USR_MODE_MASTER 1
`define USR_MODE_HS     2

`define USR_BC_ABOVF    7
`define USR_BC_IDLE     6
`define USR_BC_POL      4
`define USR_BC_WIDE     3
`define USR_BC_WAKE     1
`define USR_BC_AUTO     0

`define USR_IRQ_DONE    0
`define USR_IRQ_EN      1

`define USR_CTL_RST     1'b0
`define USR_DIV_RST     8'h00

`define USR_TPB_SLOW    7'h40
`define USR_TPB_MID     7'h10
`define USR_TPB_FAST    7'h04
`define USR_SYNC_HALF   7'h02

`endif

// ===== rtl/usr_fifo.v
/*
 Small receive FIFO of the serial port with push, pop and flush.
 Assumes the caller never pushes when full nor pops when empty.
*/
`timescale 1ns/1ns
`default_nettype none
module usr_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 2,
	parameter AW    = 1
) (
	input  wire             hclk,
	input  wire             hresetn,
	input  wire             push_i,
	input  wire [WIDTH-1:0] data_i,
	input  wire             pop_i,
	input  wire             flush_i,
	output wire [WIDTH-1:0] head_o,
	output wire             full_o,
	output wire             empty_o
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    rd_q;
	reg [AW-1:0]    wr_q;
	reg [AW:0]      cnt_q;

	assign head_o  = mem[rd_q];
	assign full_o  = (cnt_q == DEPTH[AW:0]);
	assign empty_o = (cnt_q == {(AW+1){1'b0}});

	// Storage carries no reset; only the pointers define what is valid.
	always @(posedge hclk) begin
		if (push_i) begin
			mem[wr_q] <= data_i;
		end
	end

	// Pointers wrap at DEPTH so the depth need not be a power of two.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_q  <= {AW{1'b0}};
			wr_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else if (flush_i) begin
			rd_q  <= {AW{1'b0}};
			wr_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push_i) begin
				wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
			end
			if (pop_i) begin
				rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
			end
			if (push_i && !pop_i) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop_i && !push_i) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== rtl/usr_rx.v
/*
 Receive side of the serial port: AHB-Lite register slave, baud timer,
 asynchronous and synchronous-master receive engine and two-deep FIFO.
 Assumes one clock hclk, a zero-wait bus master and an external serial slave.
*/
`timescale 1ns/1ns
`default_nettype none
`include "usr_defs.vh"
module usr_rx #(
	parameter FIFO_DEPTH = 2
) (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	input  wire        rx_dt_i,
	output reg         ck_o,
	output reg         ck_oe,
	output reg         rx_irq,
	output reg         wake_irq
);
	localparam ST_IDLE  = 3'h0;
	localparam ST_ASTRT = 3'h1;
	localparam ST_ABITS = 3'h2;
	localparam ST_ASTOP = 3'h3;
	localparam ST_SYNC  = 3'h4;

	// Control and status state.
	reg        port_en_q, nine_q, single_q, cont_q;
	reg        sync_q, master_q, hs_q;
	reg        pol_q, wide_q, wake_en_q, auto_en_q, irq_en_q;
	reg [7:0]  div_lo_q, div_hi_q;
	reg        ovr_q, ovr_cont_q;
	reg        wr_q;
	reg [7:0]  addr_q;
	reg        rx_m_q, rx_s_q, rx_prev_q, wake_seen_q;

	// Receive engine state.
	reg [2:0]  st_q;
	reg [6:0]  tick_cnt_q;
	reg [3:0]  bit_cnt_q;
	reg [8:0]  shift_q;
	reg        half_q;

	wire       tick;
	wire [8:0] head;
	wire       full, empty;

	// Zero wait states and always OKAY; every access completes in one data phase.
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	wire rd_acc   = hsel & hready & htrans[1] & ~hwrite;
	wire wr_acc   = hsel & hready & htrans[1] & hwrite;
	wire rd_data  = rd_acc & (haddr[7:0] == `USR_OFS_DATA);
	wire pop      = rd_data & ~empty;
	wire wr_any   = wr_q;
	wire wr_sta   = wr_any & (addr_q == `USR_OFS_STA);
	wire wr_bctl  = wr_any & (addr_q == `USR_OFS_BCTL);
	wire wr_div   = wr_any & ((addr_q == `USR_OFS_DIVLO) | (addr_q == `USR_OFS_DIVHI));

	// Ticks per bit time: /64, /16 or /4 in asynchronous mode.
	reg  [6:0] tpb;
	always @* begin
		if (!wide_q && !hs_q) begin
			tpb = `USR_TPB_SLOW;
		end else if (wide_q && hs_q) begin
			tpb = `USR_TPB_FAST;
		end else begin
			tpb = `USR_TPB_MID;
		end
	end

	// The synchronous clock toggles every two ticks; the start bit is checked mid-bit.
	wire [6:0] lim_half = sync_q ? (`USR_SYNC_HALF - 7'h01) : ((tpb >> 1) - 7'h01);
	wire [6:0] cnt_lim  = ((st_q == ST_ASTRT) || (st_q == ST_SYNC)) ? lim_half
		: (tpb - 7'h01);
	wire       tick_end = tick & (tick_cnt_q == cnt_lim);
	wire       last_bit = (bit_cnt_q == (nine_q ? 4'h8 : 4'h7));
	wire [8:0] sh_next  = {rx_s_q, shift_q[8:1]};
	wire       sync_smp = (st_q == ST_SYNC) & half_q & tick_end;

	// A character is complete at the async stop bit or at the last master sample.
	wire       done = ((st_q == ST_ASTOP) & tick_end) | (sync_smp & last_bit);
	wire [8:0] src  = (st_q == ST_SYNC) ? sh_next : shift_q;
	wire [8:0] chr  = nine_q ? src : {1'b0, src[8:1]};
	wire       push    = done & ~full & ~ovr_q;
	wire       ovr_set = done & full & ~ovr_q;
	wire       ovr_clr = ~port_en_q | (ovr_cont_q ? ~cont_q : rd_data);
	wire       run_ok  = port_en_q & ~ovr_q;

	// Timer restarts on divisor writes and while idle, so each character starts aligned.
	wire       brg_restart = wr_div | (st_q == ST_IDLE) | ~port_en_q;

	usr_brg #(
		.WIDTH (16)
	) u_brg (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.div_i     ({div_hi_q, div_lo_q}),
		.wide_i    (wide_q),
		.restart_i (brg_restart),
		.tick_o    (tick)
	);

	usr_fifo #(
		.WIDTH (9),
		.DEPTH (FIFO_DEPTH),
		.AW    (1)
	) u_fifo (
		.hclk    (hclk),
		.hresetn (hresetn),
		.push_i  (push),
		.data_i  (chr),
		.pop_i   (pop),
		.flush_i (~port_en_q),
		.head_o  (head),
		.full_o  (full),
		.empty_o (empty)
	);

	// Two-flop synchroniser for the data pin; only the second stage is read.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_m_q    <= 1'b1;
			rx_s_q    <= 1'b1;
			rx_prev_q <= 1'b1;
		end else begin
			rx_m_q    <= rx_dt_i;
			rx_s_q    <= rx_m_q;
			rx_prev_q <= rx_s_q;
		end
	end

	// Wake-up catches the falling edge only in asynchronous mode with the port on; the rise that follows is watched in any mode.
	wire wake_fall = wake_en_q & ~sync_q & port_en_q & rx_prev_q & ~rx_s_q;
	wire wake_rise = wake_en_q & wake_seen_q & ~rx_prev_q & rx_s_q;

	// Bus address phase is captured here; reads are answered from a flop in the data phase.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q   <= 1'b0;
			addr_q <= 8'h00;
			hrdata <= 32'h0000_0000;
		end else begin
			wr_q   <= wr_acc;
			addr_q <= haddr[7:0];
			if (rd_acc) begin
				case (haddr[7:0])
					`USR_OFS_DATA: hrdata <= {24'h00_0000, head[7:0]};
					`USR_OFS_STA: hrdata <= {24'h00_0000, port_en_q, nine_q, single_q,
						cont_q, 2'b00, ovr_q, head[8] & ~empty};
					`USR_OFS_MODE: hrdata <= {29'h0000_0000, hs_q, master_q, sync_q};
					`USR_OFS_BCTL: hrdata <= {24'h00_0000, 1'b0, (st_q == ST_IDLE), 1'b0,
						pol_q, wide_q, 1'b0, wake_en_q, auto_en_q};
					`USR_OFS_DIVLO: hrdata <= {24'h00_0000, div_lo_q};
					`USR_OFS_DIVHI: hrdata <= {24'h00_0000, div_hi_q};
					`USR_OFS_IRQ: hrdata <= {30'h0000_0000, irq_en_q, ~empty};
					default: hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Software-written configuration; write data lands at the end of the data phase.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_en_q <= `USR_CTL_RST;
			nine_q    <= `USR_CTL_RST;
			cont_q    <= `USR_CTL_RST;
			sync_q    <= `USR_CTL_RST;
			master_q  <= `USR_CTL_RST;
			hs_q      <= `USR_CTL_RST;
			pol_q     <= `USR_CTL_RST;
			wide_q    <= `USR_CTL_RST;
			auto_en_q <= `USR_CTL_RST;
			irq_en_q  <= `USR_CTL_RST;
			div_lo_q  <= `USR_DIV_RST;
			div_hi_q  <= `USR_DIV_RST;
		end else if (wr_any) begin
			case (addr_q)
				`USR_OFS_STA: begin
					port_en_q <= hwdata[`USR_STA_PORT_EN];
					nine_q    <= hwdata[`USR_STA_NINE];
					cont_q    <= hwdata[`USR_STA_CONT];
				end
				`USR_OFS_MODE: begin
					sync_q   <= hwdata[`USR_MODE_SYNC];
					master_q <= hwdata[`USR_MODE_MASTER];
					hs_q     <= hwdata[`USR_MODE_HS];
				end
				`USR_OFS_BCTL: begin
					pol_q     <= hwdata[`USR_BC_POL];
					wide_q    <= hwdata[`USR_BC_WIDE];
					auto_en_q <= hwdata[`USR_BC_AUTO];
				end
				`USR_OFS_DIVLO: div_lo_q <= hwdata[7:0];
				`USR_OFS_DIVHI: div_hi_q <= hwdata[7:0];
				`USR_OFS_IRQ: irq_en_q <= hwdata[`USR_IRQ_EN];
				default: begin
				end
			endcase
		end
	end

	// Single receive is set by software and dropped by hardware after one master character unless continuous receive is on.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			single_q <= `USR_CTL_RST;
		end else if (wr_sta) begin
			single_q <= hwdata[`USR_STA_SINGLE];
		end else if (sync_smp & last_bit & ~cont_q) begin
			single_q <= 1'b0;
		end
	end

	// Wake-up bit clears itself on the rising edge that follows the falling one.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wake_en_q   <= `USR_CTL_RST;
			wake_seen_q <= 1'b0;
			wake_irq    <= 1'b0;
		end else begin
			wake_irq <= wake_fall;
			if (wr_bctl) begin
				wake_en_q   <= hwdata[`USR_BC_WAKE];
				wake_seen_q <= 1'b0;
			end else if (wake_rise) begin
				wake_en_q   <= 1'b0;
				wake_seen_q <= 1'b0;
			end else if (wake_fall) begin
				wake_seen_q <= 1'b1;
			end
		end
	end

	// Overrun flag: a new overrun wins over a clear in the same cycle.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ovr_q      <= 1'b0;
			ovr_cont_q <= 1'b0;
		end else if (ovr_set) begin
			ovr_q      <= 1'b1;
			ovr_cont_q <= cont_q;
		end else if (ovr_q & ovr_clr) begin
			ovr_q      <= 1'b0;
			ovr_cont_q <= 1'b0;
		end
	end

	// Receive engine for both asynchronous and synchronous-master reception.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q       <= ST_IDLE;
			tick_cnt_q <= 7'h00;
			bit_cnt_q  <= 4'h0;
			shift_q    <= 9'h000;
			half_q     <= 1'b0;
		end else begin
			if (tick) begin
				tick_cnt_q <= tick_end ? 7'h00 : tick_cnt_q + 7'h01;
			end
			case (st_q)
				ST_IDLE: begin
					tick_cnt_q <= 7'h00;
					bit_cnt_q  <= 4'h0;
					half_q     <= 1'b0;
					if (run_ok && sync_q && master_q && (single_q || cont_q)) begin
						st_q <= ST_SYNC;
					end else if (run_ok && !sync_q && cont_q && !rx_s_q) begin
						st_q <= ST_ASTRT;
					end
				end
				ST_ASTRT: begin
					if (!run_ok || !cont_q) begin
						st_q <= ST_IDLE;
					end else if (tick_end) begin
						st_q <= rx_s_q ? ST_IDLE : ST_ABITS; // Glitch rejected if high mid-bit.
					end
				end
				ST_ABITS: begin
					if (!run_ok || !cont_q) begin
						st_q <= ST_IDLE;
					end else if (tick_end) begin
						shift_q   <= sh_next;
						bit_cnt_q <= bit_cnt_q + 4'h1;
						if (last_bit) begin
							st_q <= ST_ASTOP;
						end
					end
				end
				ST_ASTOP: begin
					if (!run_ok || !cont_q || tick_end) begin
						st_q <= ST_IDLE;
					end
				end
				ST_SYNC: begin
					if (!run_ok || !(single_q || cont_q)) begin
						st_q <= ST_IDLE;
					end else if (tick_end) begin
						half_q <= ~half_q;
						if (half_q) begin
							shift_q   <= sh_next;
							bit_cnt_q <= last_bit ? 4'h0 : bit_cnt_q + 4'h1;
							if (last_bit && (!cont_q || full)) begin
								st_q <= ST_IDLE;
							end
						end
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// Pin and request outputs, all registered.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ck_o   <= 1'b1;
			ck_oe  <= 1'b0;
			rx_irq <= 1'b0;
		end else begin
			ck_o   <= sync_q ? (pol_q ^ half_q) : ~pol_q;
			ck_oe  <= port_en_q & (~sync_q | master_q);
			rx_irq <= ~empty & irq_en_q;
		end
	end
endmodule
`default_nettype wire
